/* File: elr_host.sv */
// Overview of operation
// - Read needs enable and selects low, strobe high; wait access delay.
// - First rising control ends write; setup and hold reference it.
// - Selects low before strobe: wait off delay before driving data.
// - Consecutive writes may hold the strobe low throughout; here the strobe rises after every word.
`timescale 1ns/1ps
`default_nettype none
module elr_host
	import elr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ELR_ADDR_W-1:0] reqAddr,
	input wire logic [ELR_DATA_W-1:0] reqData,
	output logic reqReady,
	output logic rspValid,
	output logic [ELR_DATA_W-1:0] rspData,
	output logic enable_n,
	output logic select_one_n,
	output logic select_two_n,
	output logic strobe_n,
	output logic [ELR_ADDR_W-1:0] addrOut,
	output logic [ELR_DATA_W-1:0] dqOut,
	output logic dqOe_n,
	input wire logic [ELR_DATA_W-1:0] dqIn
);
	elr_state_t state_r, state_nxt;
	logic [ELR_CNT_W-1:0] cnt_r, cnt_nxt;
	logic en_r, en_nxt, sel_r, sel_nxt, wr_r, wr_nxt, oe_r, oe_nxt;
	logic rdy_r, rdy_nxt, rv_r, rv_nxt;
	logic stb_r, stb_nxt;
	logic [ELR_ADDR_W-1:0] addr_r, addr_nxt;
	logic [ELR_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [ELR_DATA_W-1:0] dqMeta_r, dqSync_r;

	always_ff @(posedge core_clk) begin
		dqMeta_r <= dqIn;
		dqSync_r <= dqMeta_r;
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		en_nxt = en_r;
		sel_nxt = sel_r;
		wr_nxt = wr_r;
		oe_nxt = oe_r;
		stb_nxt = stb_r;
		rdy_nxt = 1'b0;
		rv_nxt = 1'b0;
		addr_nxt = addr_r;
		wd_nxt = wd_r;
		rd_nxt = rd_r;
		unique case (state_r)
			ST_IDLE: begin
				// idle with enable and selects high
				rdy_nxt = 1'b1;
				if (reqValid && rdy_r) begin
					rdy_nxt = 1'b0;
					addr_nxt = reqAddr;
					wd_nxt = reqData;
					wr_nxt = reqWrite;
					state_nxt = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (!en_r) begin
					// enable falls a cycle after the address settles
					en_nxt = 1'b1;
					cnt_nxt = ELR_CNT_W'(ELR_HOLD_CYC);
				end else if (cnt_r == '0) begin
					if (wr_r) begin
						// strobe falls before selects, outputs stay off
						stb_nxt = 1'b1;
						cnt_nxt = ELR_CNT_W'(ELR_OFF_CYC);
						state_nxt = ST_WOFF;
					end else begin
						sel_nxt = 1'b1;
						cnt_nxt = ELR_CNT_W'(ELR_ACCESS_CYC);
						state_nxt = ST_READ;
					end
				end
			end
			ST_READ: begin
				// sample only after full access delay
				if (cnt_r == '0) begin
					rd_nxt = dqSync_r;
					rv_nxt = 1'b1;
					sel_nxt = 1'b0;
					en_nxt = 1'b0;
					cnt_nxt = ELR_CNT_W'(ELR_SELOFF_CYC);
					state_nxt = ST_GAP;
				end
			end
			ST_WOFF: begin
				// drive data a safe time after strobe fall
				oe_nxt = 1'b1;
				if (cnt_r == '0) begin
					// all controls low opens the write window
					sel_nxt = 1'b1;
					cnt_nxt = ELR_CNT_W'(ELR_PULSE_CYC > ELR_SETUP_CYC ? ELR_PULSE_CYC
						: ELR_SETUP_CYC);
					state_nxt = ST_WDATA;
				end
			end
			ST_WDATA: begin
				if (cnt_r == '0) begin
					// selects end the window first, data held past it
					sel_nxt = 1'b0;
					cnt_nxt = ELR_CNT_W'(1);
					state_nxt = ST_WEND;
				end
			end
			ST_WEND: begin
				if (cnt_r == '0) begin
					// strobe rises only after selects, so no drive-back
					oe_nxt = 1'b0;
					en_nxt = 1'b0;
					// strobe rises per word, held-low series not used
					stb_nxt = 1'b0;
					cnt_nxt = ELR_CNT_W'(ELR_SELOFF_CYC);
					state_nxt = ST_GAP;
				end
			end
			ST_GAP: begin
				wr_nxt = 1'b0;
				if (cnt_r == '0) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			en_r <= 1'b0;
			sel_r <= 1'b0;
			wr_r <= 1'b0;
			oe_r <= 1'b0;
			stb_r <= 1'b0;
			rdy_r <= 1'b0;
			rv_r <= 1'b0;
			addr_r <= '0;
			wd_r <= '0;
			rd_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			en_r <= en_nxt;
			sel_r <= sel_nxt;
			wr_r <= wr_nxt;
			oe_r <= oe_nxt;
			stb_r <= stb_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			addr_r <= addr_nxt;
			wd_r <= wd_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign enable_n = ~en_r;
	assign select_one_n = ~sel_r;
	assign select_two_n = ~sel_r;
	// strobe from its own flop, no decode glitch
	assign strobe_n = ~stb_r;
	assign addrOut = addr_r;
	assign dqOut = wd_r;
	assign dqOe_n = ~oe_r;
	assign reqReady = rdy_r;
	assign rspValid = rv_r;
	assign rspData = rd_r;

	// never drive data while device may drive
	a_no_bus_fight: assert property (@(posedge core_clk) disable iff (!rst_n)
		oe_r |-> (wr_r && stb_r)) else $error("host drives data outside write");
	// read selects only with strobe high
	a_read_strobe_high: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_r == ST_READ) |-> (strobe_n && !enable_n)) else $error("bad read control");
	a_read_access_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rv_r) |-> $past(state_r) == ST_READ) else $error("early read sample");
	a_write_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(sel_r) && wr_r |-> oe_r) else $error("data dropped before window end");
	// selects never low before strobe low in write
	a_write_sel_order: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sel_r && wr_r) |-> !strobe_n) else $error("select before strobe");
	a_addr_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
		(en_r && $past(en_r)) |-> $stable(addr_r)) else $error("address moved");
	a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_r == ST_IDLE) |-> (!en_r && !sel_r && !oe_r && !stb_r))
		else $error("idle not quiet");
	a_write_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(sel_r) && wr_r |-> sel_r [*8]) else $error("write pulse short");
	// strobe rises only once selects are high
	a_strobe_last: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(stb_r) |-> (!$past(sel_r) && !sel_r)) else $error("strobe rose before selects");
endmodule : elr_host
`default_nettype wire

/* File: elr_pkg.sv */
package elr_pkg;
	localparam int ELR_ADDR_W = 8;
	localparam int ELR_DATA_W = 4;
	localparam int ELR_CLK_NS = 25;
	// Device timing, slow grade figures in ns
	localparam int ELR_ACCESS_NS = 300;
	localparam int ELR_ENABLE_HIGH_NS = 100;
	localparam int ELR_ADDR_HOLD_NS = 50;
	localparam int ELR_OFF_DELAY_NS = 30;
	localparam int ELR_SETUP_NS = 150;
	localparam int ELR_PULSE_NS = 180;
	localparam int ELR_SEL_OFF_NS = 150;
	// Least times round up to whole cycles
	localparam int ELR_ACCESS_CYC = (ELR_ACCESS_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_HIGH_CYC = (ELR_ENABLE_HIGH_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_HOLD_CYC = (ELR_ADDR_HOLD_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_OFF_CYC = (ELR_OFF_DELAY_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_SETUP_CYC = (ELR_SETUP_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_PULSE_CYC = (ELR_PULSE_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_SELOFF_CYC = (ELR_SEL_OFF_NS + ELR_CLK_NS - 1) / ELR_CLK_NS;
	localparam int ELR_CNT_W = 5;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_READ, ST_WOFF, ST_WDATA, ST_WEND, ST_GAP
	} elr_state_t;
endpackage : elr_pkg

/* File: elr_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module elr_ram_model
	import elr_pkg::*;
(
	input wire logic enable_n,
	input wire logic select_one_n,
	input wire logic select_two_n,
	input wire logic strobe_n,
	input wire logic [ELR_ADDR_W-1:0] addrOut,
	input wire logic [ELR_DATA_W-1:0] dqOut,
	input wire logic dqOe_n,
	output logic [ELR_DATA_W-1:0] dqIn
);
	logic [ELR_DATA_W-1:0] mem [256];
	logic [ELR_ADDR_W-1:0] addrLat = '0;
	logic [ELR_DATA_W-1:0] outLat = '0;
	logic accOk = 1'b0;
	logic flip = 1'b0;
	logic sel;
	initial foreach (mem[i]) mem[i] = '0;
	// Undriven pins toggle so a stale value never looks valid
	always #25 flip = !flip;
	assign sel = !select_one_n && !select_two_n;
	always @(negedge enable_n) begin
		addrLat = addrOut;
		accOk = 1'b0;
		#(ELR_ACCESS_NS) accOk = !enable_n;
	end
	always @(posedge enable_n) outLat = mem[addrLat];
	always @(enable_n, sel, strobe_n, dqOut, dqOe_n, flip)
		if (!enable_n && sel && !strobe_n) mem[addrLat] = dqOe_n ? {4{flip}} : dqOut;
	always_comb
		if (sel && strobe_n && (enable_n || accOk)) dqIn = enable_n ? outLat : mem[addrLat];
		else dqIn = {flip, !flip, flip, !flip};
endmodule : elr_ram_model
`default_nettype wire

/* File: elr_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import elr_pkg::*;
	logic core_clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, reqReady, rspValid;
	logic enable_n, select_one_n, select_two_n, strobe_n, dqOe_n;
	logic [7:0] reqAddr = 8'h00, addrOut, seed = 8'h15;
	logic [3:0] reqData = 4'h0, rspData, dqOut, dqIn;
	logic [3:0] mirror [256];
	logic [3:0] q [$];
	int n_mismatch = 0, checked = 0, cyc = 0;
	elr_host dut(.core_clk, .rst_n, .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady,
		.rspValid, .rspData, .enable_n, .select_one_n, .select_two_n, .strobe_n, .addrOut,
		.dqOut, .dqOe_n, .dqIn);
	elr_ram_model ram(.enable_n, .select_one_n, .select_two_n, .strobe_n, .addrOut, .dqOut,
		.dqOe_n, .dqIn);
	initial forever #12.5 core_clk = !core_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic ck(input string nm, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : ck
	task automatic req(input logic w, input logic [7:0] a, input logic [3:0] d);
		reqValid = 1;
		reqWrite = w;
		reqAddr = a;
		reqData = d;
		if (w) mirror[a] = d;
		else q.push_back(mirror[a]);
		while (reqReady !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
		reqValid = 0;
		reqAddr = ~a;
		@(negedge core_clk);
	endtask : req
	task automatic end_sim;
		if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Results leave in request order
	always @(negedge core_clk) if (rspValid === 1'b1) begin
		if (q.size() == 0) ck("spurious rspData", 4'h0, 4'hx);
		else ck("rspData", q.pop_front(), rspData);
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		foreach (mirror[i]) mirror[i] = 4'h0;
		repeat (16) @(negedge core_clk);
		ck("idle controls", 4'hF, {enable_n, select_one_n, strobe_n, dqOe_n});
		ck("idle select two", 4'h1, {3'h0, select_two_n});
		rst_n = 1;
		req(1, 8'h00, 4'hA);
		req(1, 8'hFF, 4'h5);
		req(0, 8'hFF, 4'h0);
		req(0, 8'h00, 4'h0);
		req(1, 8'h00, 4'h3);
		req(0, 8'h00, 4'h0);
		repeat (80) begin
			seed = lfsr(seed);
			req(seed[0], {seed[7:5], 5'h03 ^ seed[4:0]}, seed[6:3]);
		end
		repeat (40) @(negedge core_clk);
		ck("pending reads", 4'h0, 4'(q.size()));
		end_sim();
	end
endmodule : tb
`default_nettype wire
